// [src/adbs_backend.sv]
// Converter digital back end with self-test and serial configuration port.
`timescale 1ns/1ps
module adbs_backend #(
  parameter logic [15:0] SELF_TEST_SIG = 16'h0000
) (
  // Sample clock and reset.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Converter core output.
  input wire logic [adbs_pkg::CODE_W-1:0] adc_code_i,
  input wire logic adc_over_i,
  // Multi-function output-enable pin.
  input wire logic output_enable_low_i,
  // Serial port and strap pins.
  input wire logic serial_clock_format_strap_i,
  input wire logic chip_select_n_i,
  input wire logic serial_io_sleep_strap_i,
  output logic serial_io_sleep_strap_o,
  output logic serial_io_sleep_strap_oe_o,
  // Data outputs.
  output logic [adbs_pkg::CODE_W-1:0] data_o,
  output logic over_range_o,
  output logic data_oe_o,
  output logic data_clock_out_o,
  output logic data_clock_oe_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] pn_step(input logic [15:0] r,
                                          input logic [15:0] poly);
    return r[0] ? ((r >> 1) ^ poly) : (r >> 1);
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic [11:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 11; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ adbs_pkg::CRC_POLY)
                         : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Serial clock domain declarations
  // ----------------------------------------------------------------
  logic rst_s_q1;
  logic rst_s;
  logic frame_tgl;
  logic frame_seen;
  adbs_pkg::adbs_spi_st_t st;
  logic [3:0] cnt;
  logic [15:0] sh;
  logic rd;
  logic [1:0] len;
  logic [1:0] nbytes;
  logic [12:0] addr;
  logic [7:0] rd_byte;
  logic drive;
  logic xfer_tgl;
  logic [7:0] port_cfg;
  logic [7:0] sh_pwr;
  logic [7:0] sh_test;
  logic [7:0] sh_st;
  logic [7:0] sh_fmt;
  logic [7:0] sh_phase;
  logic pass;
  logic pass_s_q1;
  logic pass_s;
  logic [15:0] next_sh;
  logic [7:0] next_byte;
  logic begin_frame;
  logic lsb_first;
  logic [2:0] bit_idx;

  function automatic logic [7:0] read_reg(input logic [12:0] a);
    case (a)
      adbs_pkg::ADDR_PORT_CFG: return port_cfg;
      adbs_pkg::ADDR_PWR_PIN: return sh_pwr;
      adbs_pkg::ADDR_TEST_SEL: return sh_test;
      adbs_pkg::ADDR_ST_CTL: return sh_st;
      adbs_pkg::ADDR_OUT_MODE: return sh_fmt;
      adbs_pkg::ADDR_OUT_PHASE: return sh_phase;
      adbs_pkg::ADDR_ST_RESULT: return {7'h00, pass_s};
      default: return adbs_pkg::REG_RST;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Serial frame control
  // ----------------------------------------------------------------
  always_ff @(posedge serial_clock_format_strap_i) begin
    rst_s_q1 <= rst_n_i;
    rst_s <= rst_s_q1;
  end

  always_ff @(negedge chip_select_n_i) begin
    frame_tgl <= ~frame_seen;
  end

  assign lsb_first = port_cfg[adbs_pkg::PORT_LSB_BIT];

  always_comb begin
    next_sh = lsb_first ? {serial_io_sleep_strap_i, sh[15:1]}
                        : {sh[14:0], serial_io_sleep_strap_i};
    next_byte = lsb_first ? next_sh[15:8] : next_sh[7:0];
    begin_frame = (frame_tgl != frame_seen) &&
                  (st == adbs_pkg::SPI_DONE ||
                   len == adbs_pkg::LEN_STREAM);
    bit_idx = lsb_first ? cnt[2:0] : 3'(adbs_pkg::BYTE_LAST - cnt);
  end

  always_ff @(posedge serial_clock_format_strap_i) begin
    if (!rst_s) begin
      st <= adbs_pkg::SPI_DONE;
      cnt <= '0;
      sh <= '0;
      rd <= 1'b0;
      len <= '0;
      nbytes <= '0;
      addr <= '0;
      frame_seen <= 1'b0;
    end else if (!chip_select_n_i) begin
      frame_seen <= frame_tgl;
      sh <= next_sh;
      if (begin_frame) begin
        st <= adbs_pkg::SPI_INSTR;
        cnt <= 4'h1;
      end else if (st == adbs_pkg::SPI_INSTR) begin
        cnt <= cnt + 4'h1;
        if (cnt == adbs_pkg::INSTR_LAST) begin
          st <= adbs_pkg::SPI_DATA;
          cnt <= '0;
          rd <= next_sh[adbs_pkg::INSTR_RW_BIT];
          len <= next_sh[14:13];
          addr <= next_sh[12:0];
          nbytes <= '0;
        end
      end else if (st == adbs_pkg::SPI_DATA) begin
        cnt <= (cnt == adbs_pkg::BYTE_LAST) ? 4'h0 : cnt + 4'h1;
        if (cnt == adbs_pkg::BYTE_LAST) begin
          addr <= addr + 13'h001;
          nbytes <= nbytes + 2'h1;
          if (len != adbs_pkg::LEN_STREAM && nbytes == len) begin
            st <= adbs_pkg::SPI_DONE;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes and readback
  // ----------------------------------------------------------------
  always_ff @(posedge serial_clock_format_strap_i) begin
    if (!rst_s) begin
      port_cfg <= adbs_pkg::REG_RST;
      sh_pwr <= adbs_pkg::REG_RST;
      sh_test <= adbs_pkg::REG_RST;
      sh_st <= adbs_pkg::REG_RST;
      sh_fmt <= adbs_pkg::REG_RST;
      sh_phase <= adbs_pkg::REG_RST;
      xfer_tgl <= 1'b0;
    end else if (!chip_select_n_i && !begin_frame && !rd &&
                 st == adbs_pkg::SPI_DATA &&
                 cnt == adbs_pkg::BYTE_LAST) begin
      case (addr)
        adbs_pkg::ADDR_PORT_CFG: port_cfg <= next_byte;
        adbs_pkg::ADDR_PWR_PIN: sh_pwr <= next_byte;
        adbs_pkg::ADDR_TEST_SEL: sh_test <= next_byte;
        adbs_pkg::ADDR_ST_CTL: sh_st <= next_byte;
        adbs_pkg::ADDR_OUT_MODE: sh_fmt <= next_byte;
        adbs_pkg::ADDR_OUT_PHASE: sh_phase <= next_byte;
        adbs_pkg::ADDR_XFER: begin
          if (next_byte[adbs_pkg::XFER_BIT]) begin
            xfer_tgl <= ~xfer_tgl;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge serial_clock_format_strap_i) begin
    if (!rst_s) begin
      rd_byte <= '0;
      pass_s_q1 <= 1'b0;
      pass_s <= 1'b0;
    end else begin
      pass_s_q1 <= pass;
      pass_s <= pass_s_q1;
      if (!chip_select_n_i && st == adbs_pkg::SPI_INSTR &&
          cnt == adbs_pkg::INSTR_LAST) begin
        rd_byte <= read_reg(next_sh[12:0]);
      end else if (!chip_select_n_i && st == adbs_pkg::SPI_DATA &&
                   cnt == adbs_pkg::BYTE_LAST) begin
        rd_byte <= read_reg(addr + 13'h001);
      end
    end
  end

  always_ff @(negedge serial_clock_format_strap_i) begin
    if (!rst_s) begin
      drive <= 1'b0;
      serial_io_sleep_strap_o <= 1'b0;
    end else begin
      drive <= rd && st == adbs_pkg::SPI_DATA;
      serial_io_sleep_strap_o <= rd_byte[bit_idx];
    end
  end

  assign serial_io_sleep_strap_oe_o = drive && !chip_select_n_i;

  // ----------------------------------------------------------------
  // Sample clock domain: pin synchronisers and transfer
  // ----------------------------------------------------------------
  logic cs_q1;
  logic cs_q2;
  logic fmt_q1;
  logic fmt_q2;
  logic slp_q1;
  logic slp_q2;
  logic oeb_q1;
  logic oeb_q2;
  logic xf_q1;
  logic xf_q2;
  logic xf_q3;
  logic spi_mode;
  logic xfer_apply;
  adbs_pkg::adbs_cfg_t cfg;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      {cs_q1, cs_q2} <= 2'h3;
      {fmt_q1, fmt_q2} <= 2'h0;
      {slp_q1, slp_q2, oeb_q1, oeb_q2} <= 4'h0;
      {xf_q1, xf_q2, xf_q3} <= 3'h0;
    end else begin
      cs_q1 <= chip_select_n_i;
      cs_q2 <= cs_q1;
      fmt_q1 <= serial_clock_format_strap_i;
      fmt_q2 <= fmt_q1;
      slp_q1 <= serial_io_sleep_strap_i;
      slp_q2 <= slp_q1;
      oeb_q1 <= output_enable_low_i;
      oeb_q2 <= oeb_q1;
      xf_q1 <= xfer_tgl;
      xf_q2 <= xf_q1;
      xf_q3 <= xf_q2;
    end
  end

  assign xfer_apply = xf_q2 ^ xf_q3;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      spi_mode <= 1'b0;
      cfg <= '0;
    end else begin
      if (cs_q2 == 1'b0) begin
        spi_mode <= 1'b1;
      end
      if (xfer_apply) begin
        cfg <= {sh_pwr, sh_test, sh_fmt, sh_phase};
      end
    end
  end

  // ----------------------------------------------------------------
  // Self-test source and test patterns
  // ----------------------------------------------------------------
  logic st_run;
  logic [9:0] st_cnt;
  logic [15:0] st_pn;
  logic [15:0] pn_long;
  logic [15:0] pn_short;
  logic alt;
  adbs_pkg::adbs_sample_t src;
  adbs_pkg::adbs_sample_t dly;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_run <= 1'b0;
      st_cnt <= '0;
      st_pn <= adbs_pkg::PN_SEED;
    end else if (xfer_apply && sh_st[adbs_pkg::ST_EN_BIT]) begin
      st_run <= 1'b1;
      st_cnt <= '0;
      if (sh_st[adbs_pkg::ST_INIT_BIT]) begin
        st_pn <= adbs_pkg::PN_SEED;
      end else begin
        st_pn <= pn_step(st_pn, adbs_pkg::PN_LONG_POLY);
      end
    end else if (st_run) begin
      st_pn <= pn_step(st_pn, adbs_pkg::PN_LONG_POLY);
      st_cnt <= st_cnt + 10'h001;
      if (st_cnt == adbs_pkg::SELF_TEST_LAST) begin
        st_run <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pn_long <= adbs_pkg::PN_SEED;
      pn_short <= adbs_pkg::PN_SEED;
      alt <= 1'b0;
    end else begin
      alt <= ~alt;
      pn_long <= cfg.test_sel[adbs_pkg::TEST_LONG_RST_BIT] ?
                 adbs_pkg::PN_SEED :
                 pn_step(pn_long, adbs_pkg::PN_LONG_POLY);
      pn_short <= cfg.test_sel[adbs_pkg::TEST_SHORT_RST_BIT] ?
                  adbs_pkg::PN_SEED :
                  pn_step(pn_short, adbs_pkg::PN_SHORT_POLY);
    end
  end

  always_comb begin
    src.tag = st_run;
    src.over = 1'b0;
    src.code = adc_code_i;
    if (st_run) begin
      src.code = st_pn[adbs_pkg::CODE_W-1:0];
    end else begin
      case (adbs_pkg::adbs_test_t'(cfg.test_sel[3:0]))
        adbs_pkg::TEST_OFF: src.over = adc_over_i;
        adbs_pkg::TEST_MID: src.code = adbs_pkg::CODE_MID;
        adbs_pkg::TEST_POS_FS: src.code = adbs_pkg::CODE_MAX;
        adbs_pkg::TEST_NEG_FS: src.code = adbs_pkg::CODE_MIN;
        adbs_pkg::TEST_CHECKER:
          src.code = alt ? adbs_pkg::CHECKER_B : adbs_pkg::CHECKER_A;
        adbs_pkg::TEST_PN_LONG:
          src.code = pn_long[adbs_pkg::CODE_W-1:0];
        adbs_pkg::TEST_PN_SHORT:
          src.code = pn_short[adbs_pkg::CODE_W-1:0];
        adbs_pkg::TEST_TOGGLE:
          src.code = alt ? adbs_pkg::CODE_MAX : adbs_pkg::CODE_MIN;
        default: src.over = adc_over_i;
      endcase
    end
  end

  adbs_delay_line #(
    .DEPTH(adbs_pkg::LATENCY_CYC)
  ) u_delay (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(src),
    .q_o(dly)
  );

  // ----------------------------------------------------------------
  // Output formatting, enables and data clock
  // ----------------------------------------------------------------
  logic twos;
  logic out_en;
  logic [adbs_pkg::CODE_W-1:0] fmt_code;
  logic dco_p;
  logic dco_n;
  logic dco_inv;

  always_comb begin
    twos = spi_mode ? (cfg.out_mode[1:0] == adbs_pkg::FMT_TWOS)
                    : fmt_q2;
    fmt_code = dly.code ^ (twos ? adbs_pkg::CODE_MSB : 12'h000);
    if (spi_mode) begin
      out_en = (cfg.pwr_pin[1:0] == adbs_pkg::PWR_NORMAL) &&
               !(cfg.pwr_pin[6:5] == adbs_pkg::PIN_FN_OEB &&
                 oeb_q2);
    end else begin
      out_en = !slp_q2;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      data_o <= '0;
      over_range_o <= 1'b0;
      data_oe_o <= 1'b0;
      data_clock_oe_o <= 1'b0;
      dco_inv <= 1'b0;
      dco_p <= 1'b0;
    end else begin
      data_o <= fmt_code;
      over_range_o <= dly.over;
      data_oe_o <= out_en;
      data_clock_oe_o <= out_en;
      dco_inv <= spi_mode && cfg.out_phase[adbs_pkg::PHASE_INV_BIT];
      dco_p <= ~dco_p;
    end
  end

  always_ff @(negedge ref_clk_i) begin
    if (!rst_n_i) begin
      dco_n <= 1'b0;
    end else begin
      dco_n <= dco_p;
    end
  end

  assign data_clock_out_o = ~(dco_p ^ dco_n) ^ dco_inv;

  // ----------------------------------------------------------------
  // Signature and result
  // ----------------------------------------------------------------
  logic [15:0] crc;
  logic [9:0] out_cnt;
  logic [15:0] next_crc;

  assign next_crc = crc_step(crc, fmt_code);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      crc <= adbs_pkg::CRC_SEED;
      out_cnt <= '0;
      pass <= 1'b0;
    end else if (xfer_apply && sh_st[adbs_pkg::ST_EN_BIT]) begin
      crc <= adbs_pkg::CRC_SEED;
      out_cnt <= '0;
      pass <= 1'b0;
    end else if (dly.tag) begin
      crc <= next_crc;
      out_cnt <= out_cnt + 10'h001;
      if (out_cnt == adbs_pkg::SELF_TEST_LAST) begin
        pass <= (next_crc == SELF_TEST_SIG);
      end
    end
  end

endmodule

// [src/adbs_delay_line.sv]
// Fixed-depth sample delay shift register, read directly from its last stage.
`timescale 1ns/1ps
module adbs_delay_line #(
  parameter int DEPTH = adbs_pkg::LATENCY_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sample in and out.
  input adbs_pkg::adbs_sample_t d_i,
  output adbs_pkg::adbs_sample_t q_o
);

  adbs_pkg::adbs_sample_t mem [DEPTH];

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      mem[0] <= d_i;
      for (int i = 1; i < DEPTH; i++) begin
        mem[i] <= mem[i-1];
      end
    end
  end

  assign q_o = mem[DEPTH-1];

endmodule

// [src/adbs_pkg.sv]
// Shared constants and types for the converter back end.
package adbs_pkg;

  // ----------------------------------------------------------------
  // Datapath sizes and timing counts
  // ----------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam int LATENCY_CYC = 9;
  localparam int SELF_TEST_CYC = 512;
  localparam logic [9:0] SELF_TEST_LAST = 10'(SELF_TEST_CYC - 1);
  localparam logic [CODE_W-1:0] CODE_MSB = 12'h800;
  localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hfff;
  localparam logic [CODE_W-1:0] CODE_MIN = 12'h000;
  localparam logic [CODE_W-1:0] CHECKER_A = 12'haaa;
  localparam logic [CODE_W-1:0] CHECKER_B = 12'h555;

  // ----------------------------------------------------------------
  // Pattern generators and signature
  // ----------------------------------------------------------------
  localparam logic [15:0] PN_LONG_POLY = 16'hb400;
  localparam logic [15:0] PN_SHORT_POLY = 16'h0110;
  localparam logic [15:0] PN_SEED = 16'h0001;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hffff;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [12:0] ADDR_PORT_CFG = 13'h000;
  localparam logic [12:0] ADDR_PWR_PIN = 13'h008;
  localparam logic [12:0] ADDR_TEST_SEL = 13'h00d;
  localparam logic [12:0] ADDR_ST_CTL = 13'h00e;
  localparam logic [12:0] ADDR_OUT_MODE = 13'h014;
  localparam logic [12:0] ADDR_OUT_PHASE = 13'h016;
  localparam logic [12:0] ADDR_ST_RESULT = 13'h024;
  localparam logic [12:0] ADDR_XFER = 13'h0ff;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int PORT_LSB_BIT = 6;
  localparam int PIN_FN_LO = 5;
  localparam logic [1:0] PIN_FN_OEB = 2'h1;
  localparam logic [1:0] PWR_NORMAL = 2'h0;
  localparam int TEST_LONG_RST_BIT = 4;
  localparam int TEST_SHORT_RST_BIT = 5;
  localparam int ST_EN_BIT = 0;
  localparam int ST_INIT_BIT = 2;
  localparam logic [1:0] FMT_TWOS = 2'h1;
  localparam int PHASE_INV_BIT = 7;
  localparam int XFER_BIT = 0;
  localparam int PASS_BIT = 0;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int INSTR_RW_BIT = 15;
  localparam logic [3:0] INSTR_LAST = 4'hf;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [1:0] LEN_STREAM = 2'h3;

  typedef enum logic [3:0] {
    TEST_OFF = 4'h0,
    TEST_MID = 4'h1,
    TEST_POS_FS = 4'h2,
    TEST_NEG_FS = 4'h3,
    TEST_CHECKER = 4'h4,
    TEST_PN_LONG = 4'h5,
    TEST_PN_SHORT = 4'h6,
    TEST_TOGGLE = 4'h7
  } adbs_test_t;

  typedef enum logic [1:0] {
    SPI_INSTR = 2'h0,
    SPI_DATA = 2'h1,
    SPI_DONE = 2'h2
  } adbs_spi_st_t;

  typedef struct packed {
    logic tag;
    logic over;
    logic [CODE_W-1:0] code;
  } adbs_sample_t;

  typedef struct packed {
    logic [7:0] pwr_pin;
    logic [7:0] test_sel;
    logic [7:0] out_mode;
    logic [7:0] out_phase;
  } adbs_cfg_t;

endpackage

// [verif/adbs_chk.sv]
// Port-level assertions for the converter back end.
`timescale 1ns/1ps
module adbs_chk (
  // Inputs of the block.
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [adbs_pkg::CODE_W-1:0] adc_code_i,
  input wire logic adc_over_i,
  input wire logic output_enable_low_i,
  input wire logic serial_clock_format_strap_i,
  input wire logic chip_select_n_i,
  input wire logic serial_io_sleep_strap_i,
  // Outputs of the block.
  input wire logic serial_io_sleep_strap_o,
  input wire logic serial_io_sleep_strap_oe_o,
  input wire logic [adbs_pkg::CODE_W-1:0] data_o,
  input wire logic over_range_o,
  input wire logic data_oe_o,
  input wire logic data_clock_out_o,
  input wire logic data_clock_oe_o
);
  logic [3:0] cyc;
  logic [3:0] quiet;
  logic spi_seen;
  logic dco_neg;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------------------------------
  // Helper state.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cyc <= 4'h0;
      spi_seen <= 1'b0;
    end else begin
      cyc <= (cyc == 4'hf) ? cyc : cyc + 4'h1;
      spi_seen <= spi_seen | !chip_select_n_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (spi_seen || serial_clock_format_strap_i || cyc != 4'hf) begin
      quiet <= 4'h0;
    end else if (quiet != 4'hf) begin
      quiet <= quiet + 4'h1;
    end
  end
  always_ff @(negedge ref_clk_i) begin
    dco_neg <= data_clock_out_o;
  end
  // ----------------------------------------------------------------
  // Properties.
  // ----------------------------------------------------------------
  sequence s_pin_sleep;
    (!spi_seen && serial_io_sleep_strap_i) [*6];
  endsequence
  sequence s_pin_off;
    (spi_seen && output_enable_low_i) [*6];
  endsequence
  sequence s_bit_out;
    $changed(serial_io_sleep_strap_o) && serial_io_sleep_strap_oe_o;
  endsequence
  property p_lat;
    (quiet == 4'hf) |-> data_o == $past(adc_code_i, 10);
  endproperty
  property p_over;
    over_range_o |-> $past(adc_over_i, 10);
  endproperty
  property p_oe_pair;
    data_clock_oe_o == data_oe_o;
  endproperty
  property p_cs_rel;
    chip_select_n_i |-> !serial_io_sleep_strap_oe_o;
  endproperty
  property p_sleep;
    s_pin_sleep |-> !data_oe_o && !data_clock_oe_o;
  endproperty
  property p_oeb;
    s_pin_off |-> !data_oe_o && !data_clock_oe_o;
  endproperty
  property p_fall;
    s_bit_out |-> !serial_clock_format_strap_i;
  endproperty
  property p_dco;
    (cyc == 4'hf) |-> data_clock_out_o != dco_neg;
  endproperty
  a_lat: assert property (p_lat)
    else $error("Data latency wrong.");
  a_over: assert property (p_over)
    else $error("Over-range without cause.");
  a_oe_pair: assert property (p_oe_pair)
    else $error("Enables differ.");
  a_cs_rel: assert property (p_cs_rel)
    else $error("Data pin driven while deselected.");
  a_sleep: assert property (p_sleep)
    else $error("Sleep strap ignored.");
  a_oeb: assert property (p_oeb)
    else $error("Enable pin ignored.");
  a_fall: assert property (p_fall)
    else $error("Read bit moved off falling edge.");
  a_dco: assert property (p_dco)
    else $error("Data clock not toggling.");
endmodule
bind adbs_backend adbs_chk u_chk (
  .ref_clk_i, .rst_n_i, .adc_code_i, .adc_over_i, .output_enable_low_i,
  .serial_clock_format_strap_i, .chip_select_n_i, .serial_io_sleep_strap_i,
  .serial_io_sleep_strap_o, .serial_io_sleep_strap_oe_o, .data_o,
  .over_range_o, .data_oe_o, .data_clock_out_o, .data_clock_oe_o
);

// [verif/adbs_host.sv]
// Serial host and strap driver on the far side of the back end.
`timescale 1ns/1ps
module adbs_host (
  // Serial pins toward the device.
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdio_o,
  output logic sdio_oe_o,
  // Resolved serial data wire.
  input wire logic sdio_i
);
  logic lsb;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b1;
    lsb = 1'b0;
  end
  task automatic pulse(input int n);
    repeat (n) begin
      #16 sclk_o = 1'b1;
      #16 sclk_o = 1'b0;
    end
  endtask
  task automatic strap(input logic fmt, input logic slp);
    sclk_o = fmt;
    sdio_o = slp;
  endtask
  task automatic bit_io(input logic d, input bit rel, output logic q);
    sdio_o = d;
    #8 sclk_o = 1'b1;
    q = sdio_i;
    #8;
    if (rel) sdio_oe_o = 1'b0;
    #8 sclk_o = 1'b0;
    #8;
  endtask
  task automatic xfer(input logic rd, input logic [12:0] a,
                      input logic [7:0] wd, input bit st,
                      output logic [7:0] rdat);
    logic [15:0] ins;
    logic [7:0] v;
    logic q;
    int i;
    int k;
    ins = {rd, 2'h0, a};
    v = 8'h00;
    cs_n_o = 1'b0;
    #8;
    for (i = 0; i < 24; i++) begin
      if (st && i == 8) begin
        cs_n_o = 1'b1;
        #40 cs_n_o = 1'b0;
        #8;
      end
      k = (i < 16) ? (lsb ? i : 15 - i) : (lsb ? i - 16 : 23 - i);
      bit_io((i < 16) ? ins[k] : wd[k], rd && i == 15, q);
      if (i > 15) v[k] = q;
    end
    cs_n_o = 1'b1;
    sdio_oe_o = 1'b1;
    rdat = v;
    #16;
  endtask
endmodule

// [verif/adc_digital_backend_spi_tb_top.sv]
// Directed testbench for the converter back end.
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module adc_digital_backend_spi_tb_top;
  logic ref_clk_i, rst_n_i, adc_over, output_enable_low, last_w, v;
  logic [11:0] adc_code, data, v0;
  logic sclk, cs_n, h_d, h_oe, s_o, s_oe, ovr, d_oe, dc_o, dc_oe;
  logic [7:0] r;
  logic [31:0] tm [7] = '{32'h01800800, 32'h02ffffff, 32'h03000000,
    32'h04aaa555, 32'h07000fff, 32'h15001001, 32'h26001001};
  int n_mismatch, num_checks;
  wire drv = s_oe ? s_o : h_d;
  wire sdio_w = (s_oe || h_oe) ? drv : ~last_w;
  always @(drv, s_oe, h_oe) if (s_oe || h_oe) last_w = drv;
  function automatic logic [15:0] sig_calc();
    logic [15:0] l, c;
    int i, b;
    l = adbs_pkg::PN_SEED;
    c = adbs_pkg::CRC_SEED;
    for (i = 0; i < adbs_pkg::SELF_TEST_CYC; i++) begin
      for (b = 11; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ l[b]) ? adbs_pkg::CRC_POLY : 16'h0);
      end
      l = (l >> 1) ^ (l[0] ? adbs_pkg::PN_LONG_POLY : 16'h0);
    end
    return c;
  endfunction
  localparam logic [15:0] EXP_SIG = sig_calc();
  adbs_backend #(.SELF_TEST_SIG(EXP_SIG)) dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .adc_code_i(adc_code),
    .adc_over_i(adc_over), .output_enable_low_i(output_enable_low),
    .serial_clock_format_strap_i(sclk), .chip_select_n_i(cs_n),
    .serial_io_sleep_strap_i(sdio_w), .serial_io_sleep_strap_o(s_o),
    .serial_io_sleep_strap_oe_o(s_oe), .data_o(data), .over_range_o(ovr),
    .data_oe_o(d_oe), .data_clock_out_o(dc_o), .data_clock_oe_o(dc_oe));
  adbs_host host (.sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(h_d),
    .sdio_oe_o(h_oe), .sdio_i(sdio_w));
  // ----------------------------------------------------------------
  // Access tasks.
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d, 1'b0, r);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e, input bit st);
    host.xfer(1'b1, a, 8'h00, st, r);
    `CHECK("read", e, r)
  endtask
  task automatic commit(input logic [12:0] a, input logic [7:0] d);
    wr(a, d);
    wr(adbs_pkg::ADDR_XFER, 8'h01);
    tick(20);
  endtask
  task automatic ramp(input logic [11:0] x);
    logic [12:0] h[$];
    for (int k = 0; k < 24; k++) begin
      tick(1);
      if (k >= 10) `CHECK("ramp", h[k-10] ^ {1'b0, x}, {ovr, data})
      h.push_back({k[1], 12'(k * 419)});
      {adc_over, adc_code} = h[k];
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog and tests.
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    #200us;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    rst_n_i = 1'b0;
    {adc_over, adc_code, output_enable_low, last_w} = '0;
    fork
      host.pulse(3);
      tick(16);
    join
    rst_n_i = 1'b1;
    host.pulse(2);
    tick(2);
    ramp(12'h000);
    host.strap(1'b1, 1'b0);
    tick(8);
    ramp(12'h800);
    host.strap(1'b0, 1'b1);
    tick(8);
    `CHECK("sleep", 2'b00, {d_oe, dc_oe})
    host.strap(1'b0, 1'b0);
    tick(8);
    `CHECK("wake", 2'b11, {d_oe, dc_oe})
    $display("test pin_mode done");
    {adc_over, adc_code} = 13'h1123;
    wr(adbs_pkg::ADDR_TEST_SEL, 8'h01);
    tick(20);
    `CHECK("shadow", 12'h123, data)
    foreach (tm[j]) begin
      commit(adbs_pkg::ADDR_TEST_SEL, tm[j][31:24]);
      v0 = data;
      tick(1);
      v = (v0 === tm[j][23:12] && data === tm[j][11:0]) ||
          (v0 === tm[j][11:0] && data === tm[j][23:12]);
      `CHECK("pattern", 1'b1, v)
      `CHECK("over", 1'b0, ovr)
    end
    commit(adbs_pkg::ADDR_TEST_SEL, 8'h01);
    commit(adbs_pkg::ADDR_OUT_MODE, 8'h01);
    `CHECK("twos", 12'h000, data)
    commit(adbs_pkg::ADDR_OUT_MODE, 8'h00);
    commit(adbs_pkg::ADDR_TEST_SEL, 8'h00);
    $display("test patterns done");
    rd(13'h003, 8'h00, 1'b0);
    wr(adbs_pkg::ADDR_ST_RESULT, 8'h01);
    rd(adbs_pkg::ADDR_ST_RESULT, 8'h00, 1'b0);
    wr(adbs_pkg::ADDR_PORT_CFG, 8'h40);
    host.lsb = 1'b1;
    wr(adbs_pkg::ADDR_TEST_SEL, 8'h03);
    rd(adbs_pkg::ADDR_TEST_SEL, 8'h03, 1'b1);
    wr(adbs_pkg::ADDR_TEST_SEL, 8'h00);
    wr(adbs_pkg::ADDR_PORT_CFG, 8'h00);
    host.lsb = 1'b0;
    rd(adbs_pkg::ADDR_PORT_CFG, 8'h00, 1'b0);
    $display("test registers done");
    commit(adbs_pkg::ADDR_PWR_PIN, 8'h20);
    output_enable_low = 1'b1;
    tick(8);
    `CHECK("oeb_hi", 2'b00, {d_oe, dc_oe})
    output_enable_low = 1'b0;
    tick(8);
    `CHECK("oeb_lo", 2'b11, {d_oe, dc_oe})
    commit(adbs_pkg::ADDR_PWR_PIN, 8'h00);
    commit(adbs_pkg::ADDR_OUT_PHASE, 8'h80);
    `CHECK("dco_inv", 1'b1, dc_o)
    commit(adbs_pkg::ADDR_OUT_PHASE, 8'h00);
    `CHECK("dco", 1'b0, dc_o)
    $display("test enable_pin done");
    commit(adbs_pkg::ADDR_ST_CTL, 8'h05);
    `CHECK("st_out", 1'b1, data !== 12'h123)
    tick(600);
    rd(adbs_pkg::ADDR_ST_RESULT, 8'h01, 1'b0);
    commit(adbs_pkg::ADDR_ST_CTL, 8'h01);
    tick(600);
    rd(adbs_pkg::ADDR_ST_RESULT, 8'h00, 1'b0);
    $display("test self_test done");
    print_verdict();
  end
endmodule
